/* logic/tmr_core.sv */
// 8-bit timer/counter with two compare units and fast PWM.
// Assumes the register strobes and the count pin are synchronous to clk.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

module tmr_core
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Register port
    input  wire tmr_bus_t         bus,
    output logic [DATA_W-1:0]     rdata_ff,
    // Interrupt service acknowledge, one per flag
    input  wire tmr_evt_t         irq_ack,
    // Pins
    input  wire logic             external_count_pin,
    output logic                  compare_output_pin_a,
    output logic                  compare_output_pin_b,
    output tmr_evt_t              irq_req_ff
);

    // =========================================================
    // Functions
    // =========================================================
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == WGM_FAST) || (m == WGM_FAST_A);
    endfunction

    // Next output state for one unit on a match
    function automatic logic match_out(input logic [2:0] m,
                                       input logic [1:0] com,
                                       input logic       cur);
        match_out = cur;
        if (is_pwm(m))
        begin
            if (com == COM_CLEAR)
                match_out = 1'b0;
            else if (com == COM_SET)
                match_out = 1'b1;
        end
        else
        begin
            unique case (com)
                COM_NONE:   match_out = cur;
                COM_TOGGLE: match_out = ~cur;
                COM_CLEAR:  match_out = 1'b0;
                COM_SET:    match_out = 1'b1;
            endcase
        end
    endfunction

    // =========================================================
    // Registers
    // =========================================================
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] count_value_ff;
    logic [7:0] compare_value_a_ff;
    logic [7:0] compare_value_b_ff;
    logic [7:0] buf_a_ff;
    logic [7:0] buf_b_ff;
    logic [2:0] timer_mask_register_ff;
    logic [2:0] timer_flag_register_ff;
    logic       oc_a_ff;
    logic       oc_b_ff;
    logic       block_ff;
    logic       ext_prev_ff;
    logic [9:0] presc_ff;

    // mode bits split over two registers
    logic [2:0] waveform_mode_field;
    logic [2:0] clock_select_field;
    logic [1:0] action_a;
    logic [1:0] action_b;
    assign waveform_mode_field = {ctrl_b_ff[CB_WGM2],
                                  ctrl_a_ff[CA_WGM_LO+1:CA_WGM_LO]};
    assign clock_select_field  = ctrl_b_ff[CB_CS_LO+2:CB_CS_LO];
    assign action_a            = ctrl_a_ff[CA_COMA_LO+1:CA_COMA_LO];
    assign action_b            = ctrl_a_ff[CA_COMB_LO+1:CA_COMB_LO];

    logic wr_ca;
    logic wr_cb;
    logic wr_cnt;
    logic wr_cmpa;
    logic wr_cmpb;
    logic wr_mask;
    logic wr_flag;
    assign wr_ca   = bus.wr && (bus.addr == REG_CTRL_A);
    assign wr_cb   = bus.wr && (bus.addr == REG_CTRL_B);
    assign wr_cnt  = bus.wr && (bus.addr == REG_COUNT);
    assign wr_cmpa = bus.wr && (bus.addr == REG_CMP_A);
    assign wr_cmpb = bus.wr && (bus.addr == REG_CMP_B);
    assign wr_mask = bus.wr && (bus.addr == REG_MASK);
    assign wr_flag = bus.wr && (bus.addr == REG_FLAG);

    // =========================================================
    // Clock select and prescaler
    // =========================================================
    logic ext_rise;
    logic ext_fall;
    logic timer_tick;
    assign ext_rise = external_count_pin && !ext_prev_ff;
    assign ext_fall = !external_count_pin && ext_prev_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ext_prev_ff <= 1'b0;
        else
            ext_prev_ff <= external_count_pin;
    end

    // Free-running; divided ticks are not phase-aligned to a select write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            presc_ff <= 10'h000;
        else
            presc_ff <= presc_ff + 10'h001;
    end

    always_comb
    begin
        unique case (clock_select_field)
            CS_STOP:     timer_tick = 1'b0;
            CS_DIV1:     timer_tick = 1'b1;
            CS_DIV8:     timer_tick = (presc_ff[2:0] == 3'h7);
            CS_DIV64:    timer_tick = (presc_ff[5:0] == 6'h3f);
            CS_DIV256:   timer_tick = (presc_ff[7:0] == 8'hff);
            CS_DIV1024:  timer_tick = (presc_ff == 10'h3ff);
            CS_EXT_FALL: timer_tick = ext_fall;
            CS_EXT_RISE: timer_tick = ext_rise;
        endcase
    end

    // =========================================================
    // Counter unit
    // =========================================================
    // bottom and top indications
    logic       at_bottom;
    logic       at_top;
    logic [7:0] top_value;
    logic       pwm;
    assign top_value = (waveform_mode_field == WGM_CLR_CMP ||
                        waveform_mode_field == WGM_FAST_A)
                       ? compare_value_a_ff : CNT_MAX;
    assign at_top    = (count_value_ff == top_value);
    assign at_bottom = (count_value_ff == CNT_BOTTOM);
    assign pwm       = is_pwm(waveform_mode_field);

    // Only up-counting modes exist here, so direction stays up
    logic direction_up;
    logic clear_cnt;
    assign direction_up = 1'b1;
    // clear at compare A; restart after top
    assign clear_cnt = at_top && (waveform_mode_field != WGM_NORMAL);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_value_ff <= RST_VAL;
        else if (wr_cnt)
            count_value_ff <= bus.wdata;
        else if (timer_tick)
        begin
            if (clear_cnt)
                count_value_ff <= CNT_BOTTOM;
            else if (direction_up)
                count_value_ff <= count_value_ff + 8'h01;
            else
                count_value_ff <= count_value_ff - 8'h01;
        end
    end

    // block held until the next tick, even while stopped
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            block_ff <= 1'b0;
        else if (wr_cnt)
            block_ff <= 1'b1;
        else if (timer_tick)
            block_ff <= 1'b0;
    end

    // =========================================================
    // Compare registers
    // =========================================================
    // 8-bit comparators
    logic match_a;
    logic match_b;
    logic load_buf;
    assign match_a  = (count_value_ff == compare_value_a_ff) && !block_ff;
    assign match_b  = (count_value_ff == compare_value_b_ff) && !block_ff;
    assign load_buf = pwm && timer_tick && clear_cnt;

    // buffers only in PWM; CPU access routing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            buf_a_ff <= RST_VAL;
            buf_b_ff <= RST_VAL;
        end
        else
        begin
            if (wr_cmpa)
                buf_a_ff <= bus.wdata;
            if (wr_cmpb)
                buf_b_ff <= bus.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            compare_value_a_ff <= RST_VAL;
            compare_value_b_ff <= RST_VAL;
        end
        else if (!pwm)
        begin
            if (wr_cmpa)
                compare_value_a_ff <= bus.wdata;
            if (wr_cmpb)
                compare_value_b_ff <= bus.wdata;
        end
        // update only at the sequence end
        else if (load_buf)
        begin
            compare_value_a_ff <= buf_a_ff;
            compare_value_b_ff <= buf_b_ff;
        end
    end

    // =========================================================
    // Control and mask
    // =========================================================
    // action fields act at once, no buffering
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a_ff              <= RST_VAL;
            ctrl_b_ff              <= RST_VAL;
            timer_mask_register_ff <= 3'h0;
        end
        else
        begin
            if (wr_ca)
                ctrl_a_ff <= bus.wdata;
            // Force bits are strobes and never stored
            if (wr_cb)
                ctrl_b_ff <= {2'b00, bus.wdata[5:0]};
            if (wr_mask)
                timer_mask_register_ff <= bus.wdata[2:0];
        end
    end

    // =========================================================
    // Flags
    // =========================================================
    tmr_evt_t set_evt;
    tmr_evt_t clr_evt;
    // match sets flag on the tick
    assign set_evt.cmpa = timer_tick && match_a;
    assign set_evt.cmpb = timer_tick && match_b;
    // overflow at zero or at top in fast PWM
    assign set_evt.ovf  = timer_tick && (pwm ? at_top : (count_value_ff
                          == CNT_MAX && !clear_cnt));
    // service or write-one clear; zeros ignored
    assign clr_evt.ovf  = irq_ack.ovf  || (wr_flag && bus.wdata[FL_OVF]);
    assign clr_evt.cmpa = irq_ack.cmpa || (wr_flag && bus.wdata[FL_CMPA]);
    assign clr_evt.cmpb = irq_ack.cmpb || (wr_flag && bus.wdata[FL_CMPB]);

    // Set beats clear so a same-cycle event is never lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            timer_flag_register_ff <= 3'h0;
        else
            timer_flag_register_ff <= set_evt
                                      | (timer_flag_register_ff & ~clr_evt);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_req_ff <= '0;
        else
            irq_req_ff <= timer_flag_register_ff & timer_mask_register_ff;
    end

    // =========================================================
    // Waveform generator
    // =========================================================
    logic force_a;
    logic force_b;
    logic nxt_oc_a;
    logic nxt_oc_b;
    assign force_a = wr_cb && bus.wdata[CB_FORCE_A] && !pwm;
    assign force_b = wr_cb && bus.wdata[CB_FORCE_B] && !pwm;

    // match, mode and action drive outputs
    always_comb
    begin
        nxt_oc_a = oc_a_ff;
        nxt_oc_b = oc_b_ff;
        if ((timer_tick && match_a) || force_a)
            nxt_oc_a = match_out(waveform_mode_field, action_a, oc_a_ff);
        if ((timer_tick && match_b) || force_b)
            nxt_oc_b = match_out(waveform_mode_field, action_b, oc_b_ff);
        // inverse level at bottom; none for zero
        if (pwm && timer_tick && clear_cnt)
        begin
            if (action_a == COM_CLEAR)
                nxt_oc_a = 1'b1;
            else if (action_a == COM_SET)
                nxt_oc_a = 1'b0;
            if (action_b == COM_CLEAR)
                nxt_oc_b = 1'b1;
            else if (action_b == COM_SET)
                nxt_oc_b = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            oc_a_ff <= 1'b0;
            oc_b_ff <= 1'b0;
        end
        else
        begin
            oc_a_ff <= nxt_oc_a;
            oc_b_ff <= nxt_oc_b;
        end
    end

    assign compare_output_pin_a = oc_a_ff;
    assign compare_output_pin_b = oc_b_ff;

    // =========================================================
    // Read port
    // =========================================================
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 8'h00;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                REG_CTRL_A: rdata_ff <= ctrl_a_ff;
                REG_CTRL_B: rdata_ff <= ctrl_b_ff;
                REG_COUNT:  rdata_ff <= count_value_ff;
                REG_CMP_A:  rdata_ff <= pwm ? buf_a_ff : compare_value_a_ff;
                REG_CMP_B:  rdata_ff <= pwm ? buf_b_ff : compare_value_b_ff;
                REG_MASK:   rdata_ff <= {5'h00, timer_mask_register_ff};
                REG_FLAG:   rdata_ff <= {5'h00, timer_flag_register_ff};
                default:    rdata_ff <= 8'h00;
            endcase
        end
        else
            rdata_ff <= 8'h00;
    end

endmodule

/* logic/tmr_pkg.sv */
// Constants, register map and types of the 8-bit dual-compare timer.
// Assumes a plain register port with read data one cycle after the strobe.
//
// Summary of operation
// - Count and compare registers are 8-bit
// - Three flags with individual mask bits
// - Tick from prescaler or external pin edge
// - Clock select zero stops the counter
// - Tick clears, increments or decrements counter; here it only clears or increments
// - CPU count write beats clear or count
// - Mode field split across control A and B
// - Bottom is 0x00, max is 0xff
// - Top is 0xff or compare A
// - Match sets compare flag on next tick
// - Flag clears on service or write one
// - Overflow flag set per mode, can interrupt
// - Compare buffering only in PWM modes
// - Buffer loads active compare at top/bottom
// - CPU reaches buffer or active register
// - Force strobe acts like match outside PWM modes, no flag
// - Count write blocks matches next tick
// - Output driven by match, mode, action
// - Output state kept across mode changes
// - Action field changes take effect immediately
// - Normal mode wraps, overflow at zero
// - Clear-on-match mode clears at compare A
// - Fast PWM set/clear at bottom and match
// - Action zero leaves output unchanged
package tmr_pkg;

    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 4;
    localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hff;

    // Register offsets
    localparam logic [3:0]  REG_CTRL_A   = 4'h0;
    localparam logic [3:0]  REG_CTRL_B   = 4'h1;
    localparam logic [3:0]  REG_COUNT    = 4'h2;
    localparam logic [3:0]  REG_CMP_A    = 4'h3;
    localparam logic [3:0]  REG_CMP_B    = 4'h4;
    localparam logic [3:0]  REG_MASK     = 4'h5;
    localparam logic [3:0]  REG_FLAG     = 4'h6;
    localparam logic [3:0]  REG_ACK      = 4'h7;

    // Field positions
    localparam int          CA_WGM_LO    = 0;
    localparam int          CA_COMB_LO   = 4;
    localparam int          CA_COMA_LO   = 6;
    localparam int          CB_CS_LO     = 0;
    localparam int          CB_WGM2      = 3;
    localparam int          CB_FORCE_B   = 6;
    localparam int          CB_FORCE_A   = 7;
    localparam int          FL_OVF       = 0;
    localparam int          FL_CMPA      = 1;
    localparam int          FL_CMPB      = 2;

    localparam logic [7:0]  RST_VAL      = 8'h00;

    // Clock select codes
    localparam logic [2:0]  CS_STOP      = 3'h0;
    localparam logic [2:0]  CS_DIV1      = 3'h1;
    localparam logic [2:0]  CS_DIV8      = 3'h2;
    localparam logic [2:0]  CS_DIV64     = 3'h3;
    localparam logic [2:0]  CS_DIV256    = 3'h4;
    localparam logic [2:0]  CS_DIV1024   = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL  = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE  = 3'h7;

    // Waveform modes
    localparam logic [2:0]  WGM_NORMAL   = 3'h0;
    localparam logic [2:0]  WGM_CLR_CMP  = 3'h2;
    localparam logic [2:0]  WGM_FAST     = 3'h3;
    localparam logic [2:0]  WGM_FAST_A   = 3'h7;

    // Output actions
    localparam logic [1:0]  COM_NONE     = 2'h0;
    localparam logic [1:0]  COM_TOGGLE   = 2'h1;
    localparam logic [1:0]  COM_CLEAR    = 2'h2;
    localparam logic [1:0]  COM_SET      = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tmr_bus_t;

    typedef struct packed {
        logic cmpb;
        logic cmpa;
        logic ovf;
    } tmr_evt_t;

endpackage

/* sim/test_tmr_core.sv */
// Self-checking bench for the 8-bit timer core.
// Drives the register port, acknowledges and count pin directly.
`timescale 1ns/1ps

`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end

module test_tmr_core
    import tmr_pkg::*;
;
    localparam int TIMEOUT = 30000;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    tmr_bus_t          bus = '0;
    tmr_evt_t          irq_ack = '0;
    logic              external_count_pin = 1'b0;
    logic [DATA_W-1:0] rdata_ff;
    logic              compare_output_pin_a;
    logic              compare_output_pin_b;
    tmr_evt_t          irq_req_ff;
    int                miscompares = 0;
    int                checks_done = 0;
    int                cycles = 0;
    int                na;
    int                nb;
    logic [7:0]        d;
    logic [1:0]        acts [5] = '{COM_TOGGLE, COM_NONE, COM_CLEAR,
                                    COM_SET, COM_TOGGLE};
    logic              pexp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0]        csl  [4] = '{CS_DIV8, CS_DIV64, CS_DIV256,
                                    CS_DIV1024};
    int                dv   [4] = '{8, 64, 256, 1024};

    tmr_core i_dut
    (
        .clk, .rst, .bus, .rdata_ff, .irq_ack, .external_count_pin,
        .compare_output_pin_a, .compare_output_pin_b, .irq_req_ff
    );

    initial forever #4 clk = ~clk;

    // ==============================================
    // Bus tasks, entered just off a clock edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        v = rdata_ff;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // High cycles of both pins over one 256-tick period
    task automatic duty(output int a, output int b);
        a = 0;
        b = 0;
        repeat (256)
        begin
            @(posedge clk);
            #1;
            a += compare_output_pin_a;
            b += compare_output_pin_b;
        end
    endtask

    task automatic pulses;
        repeat (5)
        begin
            external_count_pin <= 1'b1;
            cyc(3);
            external_count_pin <= 1'b0;
            cyc(3);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == TIMEOUT)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // ==============================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        for (int i = 0; i < 8; i++)
        begin
            rd(4'(i), d);
            `CHK(d, RST_VAL)
        end
        $display("test 1 done");
        wr(REG_COUNT, 8'h5a);
        cyc(10);
        rd(REG_COUNT, d);
        `CHK(d, 8'h5a)
        wr(REG_CMP_A, 8'ha5);
        rd(REG_CMP_A, d);
        `CHK(d, 8'ha5)
        wr(REG_CMP_B, 8'h3c);
        rd(REG_CMP_B, d);
        `CHK(d, 8'h3c)
        wr(REG_MASK, 8'h07);
        rd(REG_MASK, d);
        `CHK(d, 8'h07)
        wr(REG_MASK, 8'h00);
        $display("test 2 done");
        // Count write equal to compare A hides that match
        wr(REG_CMP_A, 8'h10);
        wr(REG_CMP_B, 8'h12);
        wr(REG_COUNT, 8'h10);
        wr(REG_CTRL_B, {5'h00, CS_DIV1});
        cyc(6);
        wr(REG_CTRL_B, 8'h00);
        rd(REG_FLAG, d);
        `CHK(d, 8'h04)
        wr(REG_FLAG, 8'h00);
        rd(REG_FLAG, d);
        `CHK(d, 8'h04)
        wr(REG_FLAG, 8'h04);
        rd(REG_FLAG, d);
        `CHK(d, 8'h00)
        $display("test 3 done");
        // Wrap through zero in normal mode
        wr(REG_COUNT, 8'hf0);
        wr(REG_CMP_A, 8'hf4);
        wr(REG_CMP_B, 8'h20);
        wr(REG_CTRL_B, {5'h00, CS_DIV1});
        cyc(30);
        wr(REG_CTRL_B, 8'h00);
        rd(REG_FLAG, d);
        `CHK(d, 8'h03)
        wr(REG_MASK, 8'h01);
        cyc(3);
        `CHK(irq_req_ff, 3'b001)
        irq_ack <= 3'b001;
        cyc(1);
        irq_ack <= 3'b000;
        cyc(3);
        rd(REG_FLAG, d);
        `CHK(d, 8'h02)
        `CHK(irq_req_ff, 3'b000)
        wr(REG_MASK, 8'h00);
        $display("test 4 done");
        // Clear-on-match keeps the count at or below compare A
        wr(REG_CTRL_A, {6'h00, WGM_CLR_CMP[1:0]});
        wr(REG_CMP_A, 8'h07);
        // Start below compare A, or the count runs on to wrap
        wr(REG_COUNT, 8'h00);
        wr(REG_FLAG, 8'h07);
        wr(REG_CTRL_B, {5'h00, CS_DIV1});
        for (int i = 0; i < 8; i++)
        begin
            rd(REG_COUNT, d);
            `CHK(d <= 8'h07, 1'b1)
        end
        wr(REG_CTRL_B, 8'h00);
        rd(REG_FLAG, d);
        `CHK(d, 8'h02)
        wr(REG_FLAG, 8'h07);
        $display("test 5 done");
        for (int u = 0; u < 2; u++)
            for (int k = 0; k < 5; k++)
            begin
                wr(REG_CTRL_A, u ? {2'h0, acts[k], 4'h0} : {acts[k], 6'h00});
                wr(REG_CTRL_B, u ? 8'h40 : 8'h80);
                cyc(3);
                d[0] = u ? compare_output_pin_b : compare_output_pin_a;
                `CHK(d[0], pexp[k])
            end
        wr(REG_CTRL_A, 8'hf0);
        wr(REG_CTRL_B, 8'hc0);
        wr(REG_CTRL_A, 8'hf3);
        cyc(3);
        `CHK({compare_output_pin_a, compare_output_pin_b}, 2'b11)
        rd(REG_FLAG, d);
        `CHK(d, 8'h00)
        $display("test 6 done");
        // Fast PWM, a non-inverting and b inverting
        wr(REG_CTRL_A, 8'hb3);
        wr(REG_CMP_A, 8'h40);
        wr(REG_CMP_B, 8'h40);
        wr(REG_CTRL_B, {5'h00, CS_DIV1});
        cyc(300);
        duty(na, nb);
        `CHK(na inside {[62:67]}, 1'b1)
        `CHK(nb inside {[188:194]}, 1'b1)
        wr(REG_CMP_A, 8'h80);
        rd(REG_CMP_A, d);
        `CHK(d, 8'h80)
        cyc(300);
        duty(na, nb);
        `CHK(na inside {[126:131]}, 1'b1)
        rd(REG_FLAG, d);
        `CHK(d[FL_OVF], 1'b1)
        wr(REG_CMP_A, 8'h3f);
        wr(REG_CTRL_B, {4'h0, 1'b1, CS_DIV1});
        cyc(300);
        for (int i = 0; i < 8; i++)
        begin
            rd(REG_COUNT, d);
            `CHK(d <= 8'h3f, 1'b1)
        end
        wr(REG_CTRL_B, 8'h00);
        wr(REG_CTRL_A, 8'h00);
        $display("test 7 done");
        wr(REG_COUNT, 8'h00);
        wr(REG_CTRL_B, {5'h00, CS_EXT_RISE});
        pulses();
        rd(REG_COUNT, d);
        `CHK(d, 8'h05)
        wr(REG_CTRL_B, {5'h00, CS_EXT_FALL});
        pulses();
        rd(REG_COUNT, d);
        `CHK(d, 8'h0a)
        // Prescaler phase is free, so allow one tick either way
        for (int k = 0; k < 4; k++)
        begin
            wr(REG_COUNT, 8'h00);
            wr(REG_CTRL_B, {5'h00, csl[k]});
            cyc(4 * dv[k]);
            wr(REG_CTRL_B, 8'h00);
            rd(REG_COUNT, d);
            `CHK(d inside {[3:5]}, 1'b1)
        end
        $display("test 8 done");
        end_of_test();
    end
endmodule

/* sim/tmr_core_chk.sv */
// Port-level checker for the timer core, bound to tmr_core.
// Shadows register writes; assumes the strobe protocol of the core.
`timescale 1ns/1ps

module tmr_core_chk
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire tmr_bus_t          bus,
    input  wire logic [DATA_W-1:0] rdata_ff,
    // Events and pins
    input  wire tmr_evt_t          irq_ack,
    input  wire logic              compare_output_pin_a,
    input  wire logic              compare_output_pin_b,
    input  wire tmr_evt_t          irq_req_ff
);
    // ==============================================
    // Shadow state
    logic [7:0] ca_ff;
    logic [7:0] cb_ff;
    logic [7:0] cnt_ff;
    logic [2:0] msk_ff;
    logic [1:0] idle_ff;
    logic       hold_ff;
    wire        wr_cb = bus.wr && bus.addr == REG_CTRL_B;
    wire        pwm   = ca_ff[1:0] == 2'h3;
    // Stopped long enough that no tick is still in flight
    wire        stop  = idle_ff == 2'h3 && cb_ff[2:0] == CS_STOP
                        && !(wr_cb && bus.wdata[2:0] != CS_STOP);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ca_ff  <= 8'h00;
            cb_ff  <= 8'h00;
            cnt_ff <= 8'h00;
            msk_ff <= 3'h0;
        end
        else if (bus.wr)
        begin
            if (bus.addr == REG_CTRL_A)
                ca_ff <= bus.wdata;
            if (wr_cb)
                cb_ff <= bus.wdata;
            if (bus.addr == REG_COUNT)
                cnt_ff <= bus.wdata;
            if (bus.addr == REG_MASK)
                msk_ff <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            idle_ff <= 2'h0;
        else if (cb_ff[2:0] != CS_STOP)
            idle_ff <= 2'h0;
        else if (idle_ff != 2'h3)
            idle_ff <= idle_ff + 2'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hold_ff <= 1'b0;
        else if (bus.wr && bus.addr == REG_COUNT)
            hold_ff <= stop;
        else if (!stop)
            hold_ff <= 1'b0;
    end

    // ==============================================
    // Properties
    default clocking cb_clk @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_mask_wr_rd;
        bus.wr && bus.addr == REG_MASK ##1 bus.rd && bus.addr == REG_MASK;
    endsequence

    sequence s_cmpb_wr_rd;
        bus.wr && bus.addr == REG_CMP_B ##1 bus.rd && bus.addr == REG_CMP_B;
    endsequence

    a_mask_readback: assert property (
        s_mask_wr_rd |=> rdata_ff == {5'h00, $past(bus.wdata[2:0], 2)})
        else $error("mask read back wrong");
    a_cmp_readback: assert property (
        s_cmpb_wr_rd |=> rdata_ff == $past(bus.wdata, 2))
        else $error("compare read back wrong");
    a_irq_masked: assert property (
        (irq_req_ff & ~(msk_ff | $past(msk_ff))) == 3'h0)
        else $error("request without mask");
    a_ack_clears: assert property (
        irq_ack.ovf && stop |=> ##1 !irq_req_ff.ovf)
        else $error("ack left request");
    a_flag_write_clears: assert property (
        bus.wr && bus.addr == REG_FLAG && bus.wdata[FL_CMPB] && stop
        |=> ##1 !irq_req_ff.cmpb)
        else $error("write one left request");
    a_pins_hold: assert property (
        stop && !wr_cb && !$past(wr_cb)
        |=> $stable(compare_output_pin_a) && $stable(compare_output_pin_b))
        else $error("pin moved while stopped");
    a_count_holds: assert property (
        hold_ff && bus.rd && bus.addr == REG_COUNT |=> rdata_ff == cnt_ff)
        else $error("stopped count moved");
    a_force_sets_a: assert property (
        wr_cb && bus.wdata[CB_FORCE_A] && !pwm && ca_ff[7:6] == COM_SET
        |=> ##[0:1] compare_output_pin_a)
        else $error("force did not set a");
    a_force_clears_b: assert property (
        wr_cb && bus.wdata[CB_FORCE_B] && !pwm && ca_ff[5:4] == COM_CLEAR
        |=> ##[0:1] !compare_output_pin_b)
        else $error("force did not clear b");
endmodule

bind tmr_core tmr_core_chk i_chk
(
    .clk, .rst, .bus, .rdata_ff, .irq_ack,
    .compare_output_pin_a, .compare_output_pin_b, .irq_req_ff
);
